// [rtl/ttc_timer_unit.sv]
// Top: three timer/counters with an APB register slave
//
// Decided for this implementation: the APB interface to the registers.
`default_nettype none
module ttc_timer_unit (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ttc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        unit_a_count_pin,
    input  wire logic                        unit_a_gate_pin,
    input  wire logic                        unit_b_count_pin,
    input  wire logic                        unit_b_gate_pin,
    input  wire logic                        unit_c_count_pin,
    input  wire logic                        trigger_pin,
    output logic                             unit_a_overflow_flag,
    output logic                             unit_b_overflow_flag,
    output logic                             unit_c_irq,
    output logic                             uart_rx_baud_clk,
    output logic                             uart_tx_baud_clk
);
    // Register state
    logic [7:0]  ab_ctrl_reg, ab_ctrl_next;
    logic [7:0]  ab_mode_reg, ab_mode_next;
    logic [7:0]  a_lo_reg, a_lo_next;
    logic [7:0]  a_hi_reg, a_hi_next;
    logic [7:0]  b_lo_reg, b_lo_next;
    logic [7:0]  b_hi_reg, b_hi_next;
    logic [7:0]  c_ctrl_reg, c_ctrl_next;
    logic [7:0]  c_mode_reg, c_mode_next;
    logic [7:0]  c_lo_reg, c_lo_next;
    logic [7:0]  c_hi_reg, c_hi_next;
    logic [7:0]  rc_lo_reg, rc_lo_next;
    logic [7:0]  rc_hi_reg, rc_hi_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        slverr_reg, slverr_next;
    logic        rx_baud_reg, rx_baud_next;
    logic        tx_baud_reg, tx_baud_next;

    // Pulses and decoded controls
    logic                   tick;
    logic                   a_fall, b_fall, c_fall, trig_fall;
    ttc_pkg::ttc_unit_cfg_t cfg_a, cfg_b;
    ttc_pkg::ttc_cnt_t      step_a, step_b;
    logic                   a_split, b_frozen;
    logic                   a_run, a_inc, b_run, b_inc, b_ovf;
    logic                   ah_inc, ah_wrap;
    logic                   a_ovf_set, b_ovf_set;
    logic                   c_inc, c_wrap, c_baud, c_trig;
    logic [15:0]            c_cnt, c_cnt_inc;
    logic                   c_ovf_set;
    logic [7:0]             idx;
    logic                   addr_ok, wr_en, setup, byte_wr;
    logic [7:0]             rd_byte;
    logic                   rd_hit;

    // Machine-cycle tick shared by all timer functions
    ttc_prescale u_prescale (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // Count pins and the trigger are sampled once per machine cycle
    ttc_edge u_edge_a (
        .pclk    (pclk),
        .presetn (presetn),
        .sample  (tick),
        .pin     (unit_a_count_pin),
        .fall    (a_fall)
    );
    ttc_edge u_edge_b (
        .pclk    (pclk),
        .presetn (presetn),
        .sample  (tick),
        .pin     (unit_b_count_pin),
        .fall    (b_fall)
    );
    ttc_edge u_edge_c (
        .pclk    (pclk),
        .presetn (presetn),
        .sample  (tick),
        .pin     (unit_c_count_pin),
        .fall    (c_fall)
    );
    ttc_edge u_edge_trig (
        .pclk    (pclk),
        .presetn (presetn),
        .sample  (tick),
        .pin     (trigger_pin),
        .fall    (trig_fall)
    );

    // One counting step of a unit A/B counter in the given mode
    function automatic ttc_pkg::ttc_cnt_t ttc_step(
        input logic [1:0] mode,
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        ttc_pkg::ttc_cnt_t r;
        logic [12:0]       v13;
        logic [15:0]       v16;
        r.hi = hi;
        r.lo = lo;
        r.ovf = 1'b0;
        v13 = {hi, lo[4:0]} + 13'h1;
        v16 = {hi, lo} + 16'h1;
        case (mode)
            ttc_pkg::MODE_13: begin
                r.hi  = v13[12:5];
                r.lo  = {lo[7:5], v13[4:0]};
                r.ovf = ({hi, lo[4:0]} == ttc_pkg::CNT13_MAX);
            end
            ttc_pkg::MODE_16: begin
                r.hi  = v16[15:8];
                r.lo  = v16[7:0];
                r.ovf = ({hi, lo} == ttc_pkg::CNT16_MAX);
            end
            ttc_pkg::MODE_8RL: begin
                r.ovf = (lo == ttc_pkg::BYTE_MAX);
                r.lo  = r.ovf ? hi : v16[7:0];
            end
            default: begin
                // Split low byte: plain eight-bit counter, high untouched
                r.lo  = v16[7:0];
                r.ovf = (lo == ttc_pkg::BYTE_MAX);
            end
        endcase
        return r;
    endfunction : ttc_step

    // Units A and B: enables, steps and flag sets
    always_comb begin
        cfg_a    = ttc_pkg::ttc_unit_cfg_t'(
                       ab_mode_reg[ttc_pkg::MODE_A_LSB +: 4]);
        cfg_b    = ttc_pkg::ttc_unit_cfg_t'(
                       ab_mode_reg[ttc_pkg::MODE_B_LSB +: 4]);
        a_split  = (cfg_a.mode == ttc_pkg::MODE_SPLIT);
        b_frozen = (cfg_b.mode == ttc_pkg::MODE_SPLIT);
        a_run    = ab_ctrl_reg[ttc_pkg::TC_A_RUN]
                   & (~cfg_a.gate | unit_a_gate_pin);
        a_inc    = a_run & (cfg_a.counter ? a_fall : tick);
        step_a   = ttc_step(cfg_a.mode, a_hi_reg, a_lo_reg);
        // Split high byte counts machine cycles under unit B's run bit
        ah_inc   = a_split & ab_ctrl_reg[ttc_pkg::TC_B_RUN] & tick;
        ah_wrap  = ah_inc & (a_hi_reg == ttc_pkg::BYTE_MAX);
        // With A split, B's run bit belongs to A; B runs, subject to its gate, unless in mode 3
        b_run    = (a_split ? 1'b1 : ab_ctrl_reg[ttc_pkg::TC_B_RUN])
                   & ~b_frozen
                   & (~cfg_b.gate | unit_b_gate_pin);
        b_inc    = b_run & (cfg_b.counter ? b_fall : tick);
        step_b   = ttc_step(cfg_b.mode, b_hi_reg, b_lo_reg);
        b_ovf    = b_inc & step_b.ovf;
        a_ovf_set = a_inc & step_a.ovf;
        b_ovf_set = a_split ? ah_wrap : b_ovf;
    end

    // Unit C: source, wrap and trigger decode
    always_comb begin
        c_cnt     = {c_hi_reg, c_lo_reg};
        c_cnt_inc = c_cnt + 16'h1;
        c_inc     = c_ctrl_reg[ttc_pkg::C_RUN]
                    & (c_ctrl_reg[ttc_pkg::C_SRC] ? c_fall : tick);
        c_wrap    = c_inc & (c_cnt == ttc_pkg::CNT16_MAX);
        c_baud    = c_ctrl_reg[ttc_pkg::C_RXSEL]
                    | c_ctrl_reg[ttc_pkg::C_TXSEL];
        c_trig    = trig_fall & c_ctrl_reg[ttc_pkg::C_TRIGEN];
        c_ovf_set = c_wrap & ~c_baud;
    end

    // APB decode; the slave never inserts wait states
    always_comb begin
        idx     = paddr[ttc_pkg::IDX_MSB:ttc_pkg::IDX_LSB];
        addr_ok = (paddr[ttc_pkg::ADDR_W-1:ttc_pkg::IDX_MSB+1]
                   == ttc_pkg::ADDR_TOP_OK);
        setup   = psel & ~penable;
        wr_en   = psel & penable & pwrite & ~slverr_reg;
        byte_wr = wr_en & pstrb[0];
    end

    // Read mux; unmapped addresses answer with an error
    always_comb begin
        rd_byte = ttc_pkg::REG_RESET;
        rd_hit  = addr_ok;
        case (idx)
            ttc_pkg::IDX_A_B_CONTROL:   rd_byte = ab_ctrl_reg;
            ttc_pkg::IDX_A_B_MODE:      rd_byte = ab_mode_reg;
            ttc_pkg::IDX_A_COUNT_LOW:   rd_byte = a_lo_reg;
            ttc_pkg::IDX_B_COUNT_LOW:   rd_byte = b_lo_reg;
            ttc_pkg::IDX_A_COUNT_HIGH:  rd_byte = a_hi_reg;
            ttc_pkg::IDX_B_COUNT_HIGH:  rd_byte = b_hi_reg;
            ttc_pkg::IDX_C_CONTROL:     rd_byte = c_ctrl_reg;
            ttc_pkg::IDX_C_MODE:        rd_byte = c_mode_reg;
            ttc_pkg::IDX_C_RELOAD_LOW:  rd_byte = rc_lo_reg;
            ttc_pkg::IDX_C_RELOAD_HIGH: rd_byte = rc_hi_reg;
            ttc_pkg::IDX_C_COUNT_LOW:   rd_byte = c_lo_reg;
            ttc_pkg::IDX_C_COUNT_HIGH:  rd_byte = c_hi_reg;
            default:                    rd_hit  = 1'b0;
        endcase
        if (!addr_ok) begin
            rd_byte = ttc_pkg::REG_RESET;  // Refused: reads as zero
        end
    end

    // Next state of all registers but the baud pulses; hardware flag sets beat software clears
    always_comb begin
        ab_ctrl_next = ab_ctrl_reg;
        ab_mode_next = ab_mode_reg;
        a_lo_next    = a_lo_reg;
        a_hi_next    = a_hi_reg;
        b_lo_next    = b_lo_reg;
        b_hi_next    = b_hi_reg;
        c_ctrl_next  = c_ctrl_reg;
        c_mode_next  = c_mode_reg;
        c_lo_next    = c_lo_reg;
        c_hi_next    = c_hi_reg;
        rc_lo_next   = rc_lo_reg;
        rc_hi_next   = rc_hi_reg;
        prdata_next  = prdata_reg;
        slverr_next  = slverr_reg;

        // Unit A counting
        if (a_inc) begin
            a_lo_next = step_a.lo;
            if (!a_split) begin
                a_hi_next = step_a.hi;
            end
        end
        if (ah_inc) begin
            a_hi_next = a_hi_reg + 8'h1;
        end
        // Unit B counting; frozen mode never reaches here with b_inc high
        if (b_inc) begin
            b_lo_next = step_b.lo;
            b_hi_next = step_b.hi;
        end

        // Unit C counting, reload and capture
        if (c_inc) begin
            c_lo_next = c_cnt_inc[7:0];
            c_hi_next = c_cnt_inc[15:8];
        end
        if (c_ctrl_reg[ttc_pkg::C_CAPSEL] && !c_baud) begin
            // Capture keeps counting; the count just wraps to zero
            if (c_trig) begin
                rc_lo_next = c_lo_reg;
                rc_hi_next = c_hi_reg;
            end
        end else if (c_wrap || (c_trig && !c_baud)) begin
            c_lo_next = rc_lo_reg;
            c_hi_next = rc_hi_reg;
        end

        // Software writes; a count write overrides the same-cycle step
        if (byte_wr) begin
            case (idx)
                ttc_pkg::IDX_A_B_CONTROL:   ab_ctrl_next = pwdata[7:0];
                ttc_pkg::IDX_A_B_MODE:      ab_mode_next = pwdata[7:0];
                ttc_pkg::IDX_A_COUNT_LOW:   a_lo_next    = pwdata[7:0];
                ttc_pkg::IDX_B_COUNT_LOW:   b_lo_next    = pwdata[7:0];
                ttc_pkg::IDX_A_COUNT_HIGH:  a_hi_next    = pwdata[7:0];
                ttc_pkg::IDX_B_COUNT_HIGH:  b_hi_next    = pwdata[7:0];
                ttc_pkg::IDX_C_CONTROL:     c_ctrl_next  = pwdata[7:0];
                ttc_pkg::IDX_C_MODE:        c_mode_next  = pwdata[7:0];
                ttc_pkg::IDX_C_RELOAD_LOW:  rc_lo_next   = pwdata[7:0];
                ttc_pkg::IDX_C_RELOAD_HIGH: rc_hi_next   = pwdata[7:0];
                ttc_pkg::IDX_C_COUNT_LOW:   c_lo_next    = pwdata[7:0];
                ttc_pkg::IDX_C_COUNT_HIGH:  c_hi_next    = pwdata[7:0];
                default: begin
                end
            endcase
        end

        // Sticky flags: only software clears them
        if (a_ovf_set) begin
            ab_ctrl_next[ttc_pkg::TC_A_OVF] = 1'b1;
        end
        if (b_ovf_set) begin
            ab_ctrl_next[ttc_pkg::TC_B_OVF] = 1'b1;
        end
        if (c_ovf_set) begin
            c_ctrl_next[ttc_pkg::C_OVF] = 1'b1;
        end
        if (c_trig) begin
            c_ctrl_next[ttc_pkg::C_EXT] = 1'b1;
        end

        // Read data and error are caught in the setup cycle
        if (setup) begin
            prdata_next = {ttc_pkg::PAD_ZERO, rd_byte};
            slverr_next = ~rd_hit;
        end
    end

    // Baud pulses: unit A is never a candidate source
    always_comb begin
        rx_baud_next = c_ctrl_reg[ttc_pkg::C_RXSEL]
                       ? c_wrap : b_ovf;
        tx_baud_next = c_ctrl_reg[ttc_pkg::C_TXSEL]
                       ? c_wrap : b_ovf;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ab_ctrl_reg <= ttc_pkg::REG_RESET;
            ab_mode_reg <= ttc_pkg::REG_RESET;
            a_lo_reg    <= ttc_pkg::REG_RESET;
            a_hi_reg    <= ttc_pkg::REG_RESET;
            b_lo_reg    <= ttc_pkg::REG_RESET;
            b_hi_reg    <= ttc_pkg::REG_RESET;
            c_ctrl_reg  <= ttc_pkg::REG_RESET;
            c_mode_reg  <= ttc_pkg::REG_RESET;
            c_lo_reg    <= ttc_pkg::REG_RESET;
            c_hi_reg    <= ttc_pkg::REG_RESET;
            rc_lo_reg   <= ttc_pkg::REG_RESET;
            rc_hi_reg   <= ttc_pkg::REG_RESET;
            prdata_reg  <= {ttc_pkg::PAD_ZERO, ttc_pkg::REG_RESET};
            slverr_reg  <= 1'b0;
            rx_baud_reg <= 1'b0;
            tx_baud_reg <= 1'b0;
        end else begin
            ab_ctrl_reg <= ab_ctrl_next;
            ab_mode_reg <= ab_mode_next;
            a_lo_reg    <= a_lo_next;
            a_hi_reg    <= a_hi_next;
            b_lo_reg    <= b_lo_next;
            b_hi_reg    <= b_hi_next;
            c_ctrl_reg  <= c_ctrl_next;
            c_mode_reg  <= c_mode_next;
            c_lo_reg    <= c_lo_next;
            c_hi_reg    <= c_hi_next;
            rc_lo_reg   <= rc_lo_next;
            rc_hi_reg   <= rc_hi_next;
            prdata_reg  <= prdata_next;
            slverr_reg  <= slverr_next;
            rx_baud_reg <= rx_baud_next;
            tx_baud_reg <= tx_baud_next;
        end
    end

    // Outputs; the interrupt enable lives in the interrupt controller
    always_comb begin
        prdata               = prdata_reg;
        pready               = 1'b1;
        pslverr              = slverr_reg & psel & penable;
        unit_a_overflow_flag = ab_ctrl_reg[ttc_pkg::TC_A_OVF];
        unit_b_overflow_flag = ab_ctrl_reg[ttc_pkg::TC_B_OVF];
        unit_c_irq           = c_ctrl_reg[ttc_pkg::C_OVF]
                               | c_ctrl_reg[ttc_pkg::C_EXT];
        uart_rx_baud_clk     = rx_baud_reg;
        uart_tx_baud_clk     = tx_baud_reg;
    end
endmodule : ttc_timer_unit
`default_nettype wire

// [rtl/ttc_pkg.sv]
// Package: register map, field layout and constants of the triple timer
`default_nettype none
package ttc_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_A_B_CONTROL    = 8'h88;
    localparam logic [7:0] IDX_A_B_MODE       = 8'h89;
    localparam logic [7:0] IDX_A_COUNT_LOW    = 8'h8A;
    localparam logic [7:0] IDX_B_COUNT_LOW    = 8'h8B;
    localparam logic [7:0] IDX_A_COUNT_HIGH   = 8'h8C;
    localparam logic [7:0] IDX_B_COUNT_HIGH   = 8'h8D;
    localparam logic [7:0] IDX_C_CONTROL      = 8'hC8;
    localparam logic [7:0] IDX_C_MODE         = 8'hC9;
    localparam logic [7:0] IDX_C_RELOAD_LOW   = 8'hCA;
    localparam logic [7:0] IDX_C_RELOAD_HIGH  = 8'hCB;
    localparam logic [7:0] IDX_C_COUNT_LOW    = 8'hCC;
    localparam logic [7:0] IDX_C_COUNT_HIGH   = 8'hCD;

    // APB address split
    localparam int         ADDR_W      = 12;
    localparam int         IDX_LSB     = 2;
    localparam int         IDX_MSB     = 9;
    localparam logic [1:0] ADDR_TOP_OK = 2'h0;

    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [7:0] BYTE_MAX    = 8'hFF;
    localparam logic [12:0] CNT13_MAX  = 13'h1FFF;
    localparam logic [15:0] CNT16_MAX  = 16'hFFFF;
    localparam logic [23:0] PAD_ZERO   = 24'h000000;

    // Shared control register of units A and B
    localparam int TC_B_OVF = 7;
    localparam int TC_B_RUN = 6;
    localparam int TC_A_OVF = 5;
    localparam int TC_A_RUN = 4;

    // Unit C control register
    localparam int C_OVF    = 7;
    localparam int C_EXT    = 6;
    localparam int C_RXSEL  = 5;
    localparam int C_TXSEL  = 4;
    localparam int C_TRIGEN = 3;
    localparam int C_RUN    = 2;
    localparam int C_SRC    = 1;
    localparam int C_CAPSEL = 0;

    // Mode nibble positions inside the A/B mode register
    localparam int MODE_A_LSB = 0;
    localparam int MODE_B_LSB = 4;

    // Timer function advances once per machine cycle of six clocks
    localparam int         TICK_DIV   = 6;
    localparam logic [2:0] TICK_LAST  = 3'(TICK_DIV - 1);
    localparam logic [2:0] TICK_ZERO  = 3'h0;
    localparam logic [2:0] TICK_ONE   = 3'h1;

    // Counting modes of units A and B
    localparam logic [1:0] MODE_13   = 2'h0;
    localparam logic [1:0] MODE_16   = 2'h1;
    localparam logic [1:0] MODE_8RL  = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // One nibble of the A/B mode register
    typedef struct packed {
        logic       gate;
        logic       counter;
        logic [1:0] mode;
    } ttc_unit_cfg_t;

    // Result of one counting step
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic       ovf;
    } ttc_cnt_t;

endpackage : ttc_pkg
`default_nettype wire

// [rtl/ttc_prescale.sv]
// Machine-cycle prescaler and sampled falling-edge detector
`default_nettype none
module ttc_prescale (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;

    // Divide by six; tick marks the last clock of a machine cycle
    always_comb begin
        tick     = (cnt_reg == ttc_pkg::TICK_LAST);
        cnt_next = tick ? ttc_pkg::TICK_ZERO : cnt_reg + ttc_pkg::TICK_ONE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= ttc_pkg::TICK_ZERO;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : ttc_prescale

module ttc_edge (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic sample,
    input  wire logic pin,
    output logic      fall
);
    logic prev_reg;
    logic prev_next;

    // High in one sample and low in the next counts as one falling edge
    always_comb begin
        fall      = sample & prev_reg & ~pin;
        prev_next = sample ? pin : prev_reg;
    end

    // Reset to low so that a pin held low at start gives no edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
        end
    end
endmodule : ttc_edge
`default_nettype wire

// [bench/ttc_properties.sv]
// Checker of port timing of the triple timer, bound to its top
`default_nettype none
module ttc_properties (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [ttc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       unit_a_overflow_flag,
    input wire logic                       unit_b_overflow_flag,
    input wire logic                       unit_c_irq,
    input wire logic                       uart_rx_baud_clk,
    input wire logic                       uart_tx_baud_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed write phase; only this may lower a sticky flag
    logic wr;
    assign wr = psel && penable && pwrite;

    AST_A_STICKY: assert property ($fell(unit_a_overflow_flag) |-> $past(wr))
        else $error("A flag dropped without a write");
    AST_B_STICKY: assert property ($fell(unit_b_overflow_flag) |-> $past(wr))
        else $error("B flag dropped without a write");
    AST_IRQ_STICKY: assert property ($fell(unit_c_irq) |-> $past(wr))
        else $error("C request dropped without a write");
    // Wraps come from machine ticks, so pulses are at least six clocks apart
    AST_RX_SPACING: assert property (uart_rx_baud_clk |=> !uart_rx_baud_clk [*5])
        else $error("rx baud pulses too close");
    AST_TX_SPACING: assert property (uart_tx_baud_clk |=> !uart_tx_baud_clk [*5])
        else $error("tx baud pulses too close");
    AST_ERR_TOP: assert property (psel && !penable && paddr[11:10] != 2'h0
        |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");
    AST_ERR_ACCESS: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    AST_PRDATA_HI: assert property (prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
endmodule : ttc_properties

bind ttc_timer_unit ttc_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .unit_a_overflow_flag(unit_a_overflow_flag),
    .unit_b_overflow_flag(unit_b_overflow_flag), .unit_c_irq(unit_c_irq),
    .uart_rx_baud_clk(uart_rx_baud_clk), .uart_tx_baud_clk(uart_tx_baud_clk));
`default_nettype wire

// [bench/ttc_pins_model.sv]
// Far-side pin model: square wave on the count pins while asked
`default_nettype none
module ttc_pins_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic go,
    output logic      count_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] ph_reg;
    // Phase restarts whenever pulses stop, pin rests low as if pulled down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ph_reg <= 5'h00;
        else if (!go || ph_reg == 5'h17) ph_reg <= 5'h00;
        else ph_reg <= ph_reg + 5'h01;
    end
    // Twelve clocks each level, so every level spans two machine samples
    assign count_pin = go && ph_reg < 5'h0C;
endmodule : ttc_pins_model
`default_nettype wire

// [bench/ttc_timer_unit_tb.sv]
// Self-checking bench of the triple timer over APB and its pins
`default_nettype none
module ttc_timer_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, ga = 1'b0, gb = 1'b0, tr = 1'b1, go = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, fa, fb, irq, rxc, txc, cpin;
    logic [2:0]  ev;
    logic [8:0]  expq[$];
    logic [7:0]  d;
    logic [7:0]  lo_i[3] = '{8'hBF, 8'hFF, 8'hFF};
    logic [7:0]  hi_i[3] = '{8'hFF, 8'hFF, 8'h5A};
    logic [7:0]  lo_e[3] = '{8'hA0, 8'h00, 8'h5A};
    logic [7:0]  hi_e[3] = '{8'h00, 8'h00, 8'h5A};
    int mismatches = 0, cmp_count = 0, rx_n = 0, tx_n = 0, r0, t0;
    assign ev = {irq, fb, fa};
    always #5 pclk = ~pclk;
    ttc_timer_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .unit_a_count_pin(cpin), .unit_a_gate_pin(ga),
        .unit_b_count_pin(cpin), .unit_b_gate_pin(gb),
        .unit_c_count_pin(cpin), .trigger_pin(tr),
        .unit_a_overflow_flag(fa), .unit_b_overflow_flag(fb),
        .unit_c_irq(irq), .uart_rx_baud_clk(rxc), .uart_tx_baud_clk(txc));
    ttc_pins_model pins (.pclk(pclk), .presetn(presetn), .go(go),
        .count_pin(cpin));
    task complete_run();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    task chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Request held from setup until pready is seen at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] i, input logic [7:0] v);
        apb(1'b1, {2'h0, i, 2'h0}, v);
    endtask : wr
    task rd(input logic [7:0] i, input logic [7:0] v);
        expq.push_back({1'b0, v});
        apb(1'b0, {2'h0, i, 2'h0}, 8'h00);
    endtask : rd
    // Bounded wait for one of the flag outputs
    task wt(input int s);
        repeat (400) begin
            @(posedge pclk);
            if (ev[s] === 1'b1) break;
        end
        chk({8'h00, ev[s]}, 9'h001);
    endtask : wt
    // Baud pulses over 120 clocks, a whole number of machine cycles
    task pulses(input int er, input int et);
        repeat (12) @(posedge pclk);
        r0 = rx_n;
        t0 = tx_n;
        repeat (120) @(posedge pclk);
        chk(9'(rx_n - r0), 9'(er));
        chk(9'(tx_n - t0), 9'(et));
    endtask : pulses
    task trig();
        tr <= 1'b0;
        repeat (20) @(posedge pclk);
        tr <= 1'b1;
        repeat (20) @(posedge pclk);
    endtask : trig
    always @(posedge pclk) begin
        if (rxc === 1'b1) rx_n <= rx_n + 1;
        if (txc === 1'b1) tx_n <= tx_n + 1;
    end
    // Oldest noted read result is compared as each read completes
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1)
            chk({pslverr, prdata[7:0]}, expq.pop_front());
    end
    initial begin
        void'($urandom(32'h78C34D54));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(8'h88 + 8'(i), 8'h00);
            rd(8'hC8 + 8'(i), 8'h00);
        end
        // Modes 0..2 from their top value; gate holds until opened
        for (int m = 0; m < 3; m++) begin
            wr(8'h8A, lo_i[m]);
            wr(8'h8C, hi_i[m]);
            wr(8'h89, {6'h02, 2'(m)});
            wr(8'h88, 8'h10);
            repeat (30) @(posedge pclk);
            chk({8'h00, fa}, 9'h000);
            ga <= 1'b1;
            wt(0);
            ga <= 1'b0;
            wr(8'h88, 8'h00);
            rd(8'h8A, lo_e[m]);
            rd(8'h8C, hi_e[m]);
            rd(8'h88, 8'h00);
        end
        // B wraps every tick, A climbs from 5A without wrapping; of A and B only B may reach the baud lines
        wr(8'h8C, 8'hFF);
        wr(8'h8B, 8'hFF);
        wr(8'h8D, 8'hFF);
        wr(8'h89, 8'h22);
        wr(8'h88, 8'h50);
        pulses(20, 20);
        chk({8'h00, fb}, 9'h001);
        wr(8'hC8, 8'h20);
        pulses(0, 20);
        wr(8'h89, 8'h32);
        wr(8'h8B, 8'h10);
        pulses(0, 0);
        rd(8'h8B, 8'h10);
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h33);
        wr(8'h88, 8'h40);
        wt(1);
        wr(8'h88, 8'h00);
        // Unit C reload on wrap, then held once stopped
        wr(8'hC8, 8'h00);
        wr(8'hCA, 8'h34);
        wr(8'hCB, 8'h12);
        wr(8'hCC, 8'hFF);
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'h04);
        wt(2);
        wr(8'hC8, 8'h80);
        repeat (30) @(posedge pclk);
        rd(8'hCC, 8'h34);
        rd(8'hCD, 8'h12);
        rd(8'hC8, 8'h80);
        // Trigger falls: capture, reload, then ignored when disabled
        wr(8'hCC, 8'h55);
        wr(8'hC8, 8'h09);
        trig();
        rd(8'hCA, 8'h55);
        rd(8'hCB, 8'h12);
        rd(8'hC8, 8'h49);
        wr(8'hCC, 8'h77);
        wr(8'hC8, 8'h08);
        trig();
        rd(8'hCC, 8'h55);
        rd(8'hC8, 8'h48);
        wr(8'hC8, 8'h01);
        wr(8'hCC, 8'h66);
        trig();
        rd(8'hCA, 8'h55);
        rd(8'hC8, 8'h01);
        // Five pin falls counted by unit C in counter function
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h06);
        go <= 1'b1;
        repeat (110) @(posedge pclk);
        go <= 1'b0;
        repeat (30) @(posedge pclk);
        rd(8'hCC, 8'h05);
        wr(8'hC8, 8'h00);
        repeat (4) begin
            d = 8'($urandom);
            wr(8'hC9, d);
            rd(8'hC9, d);
        end
        // Unmapped read and write are refused
        expq.push_back(9'h100);
        apb(1'b0, 12'hC00, 8'h00);
        apb(1'b1, 12'hA20, 8'hFF);
        rd(8'h88, 8'h00);
        complete_run();
    end
    // The run needs about a thousand clocks; this cuts a hang short
    initial begin
        #200000;
        mismatches++;
        complete_run();
    end
endmodule : ttc_timer_unit_tb
`default_nettype wire
